// >>> verilog/fpec_pkg.sv
package fpec_pkg;

   // Register file addresses
   localparam logic [11:0] ADDR_COMMAND   = 12'hff8;
   localparam logic [11:0] ADDR_PAGE_SEL  = 12'hff9;
   localparam logic [11:0] ADDR_KHZ_HIGH  = 12'hffa;
   localparam logic [11:0] ADDR_KHZ_LOW   = 12'hffb;

   // Command codes
   localparam logic [7:0] CMD_UNLOCK_1    = 8'h73;
   localparam logic [7:0] CMD_UNLOCK_2    = 8'h8c;
   localparam logic [7:0] CMD_PAGE_ERASE  = 8'h95;
   localparam logic [7:0] CMD_MASS_ERASE  = 8'h63;
   localparam logic [7:0] CMD_PROT_ACCESS = 8'h5e;

   // State field codes
   localparam logic [5:0] ST_LOCKED   = 6'h00;
   localparam logic [5:0] ST_FIRST    = 6'h01;
   localparam logic [5:0] ST_SECOND   = 6'h02;
   localparam logic [5:0] ST_UNLOCKED = 6'h03;
   localparam logic [5:0] ST_PROT_SEL = 6'h04;
   localparam logic [5:0] ST_PROGRAM  = 6'h08;
   localparam logic [5:0] ST_PAGE_ER  = 6'h10;
   localparam logic [5:0] ST_MASS_ER  = 6'h20;

   // Field positions and reset values
   localparam int          INFO_BIT       = 7;
   localparam logic [7:0]  REG_RESET      = 8'h00;
   localparam logic [15:0] INFO_BASE      = 16'hfe00;
   localparam logic [15:0] USER_LIMIT     = 16'h2000;
   localparam logic [15:0] VENDOR_LIMIT   = 16'h3000;
   localparam int          PAGE_LSB       = 9;
   localparam int          SECTOR_BITS    = 8;

   // Erase and program timing: microseconds of flash time per operation
   localparam int          PAGE_ERASE_US  = 10000;
   localparam int          MASS_ERASE_US  = 200000;
   localparam int          PROGRAM_US     = 40;
   localparam logic [9:0]  MS_TO_US_DIV   = 10'h3e8;

   // Register bus request from CPU or debugger
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [11:0] addr;
      logic [7:0]  wdata;
      logic        debug;
   } fpec_reg_req_t;

   // Memory access request to check against protection
   typedef struct packed {
      logic        valid;
      logic        write;
      logic [15:0] addr;
      logic        from_vendor;
   } fpec_mem_req_t;

endpackage

// >>> verilog/fpec_tick.sv
`timescale 1ns/100ps
`default_nettype none
// One enable pulse per microsecond of flash time, scaled by the kHz value, for 1000 kHz and up; slower clocks get one pulse per cycle
module fpec_tick
   import fpec_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        reset,
   input  wire logic        run,
   input  wire logic [15:0] khz,
   output logic             tick_us
);
   typedef struct packed {
      logic [25:0] acc;
      logic        tick;
   } fpec_tick_state_t;

   fpec_tick_state_t st;
   fpec_tick_state_t next_st;

   // Accumulate 1000 per cycle; a tick each time khz worth is gathered
   always_comb begin
      next_st = st;
      next_st.tick = 1'b0;
      if (!run) begin
         next_st.acc = 26'h0;
      end else if (st.acc + 26'(MS_TO_US_DIV) >= {khz, 10'h000} >> 10) begin
         next_st.acc  = st.acc + 26'(MS_TO_US_DIV) - 26'(khz);
         next_st.tick = 1'b1;
      end else begin
         next_st.acc = st.acc + 26'(MS_TO_US_DIV);
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign tick_us = st.tick;
endmodule
`default_nettype wire

// >>> verilog/fpec_guard.sv
`timescale 1ns/100ps
`default_nettype none
// Access gate for the reserved vendor region; every address outside it is granted
module fpec_guard
   import fpec_pkg::*;
(
   input  wire logic          clk,
   input  wire logic          reset,
   input  wire fpec_mem_req_t req,
   output logic               grant,
   output logic               deny
);
   typedef struct packed {
      logic grant;
      logic deny;
   } fpec_guard_state_t;

   fpec_guard_state_t st;
   fpec_guard_state_t next_st;
   logic              in_vendor;

   // Vendor area sits above user space; only its own code may touch it
   always_comb begin
      in_vendor = (req.addr >= USER_LIMIT) && (req.addr < VENDOR_LIMIT); // R18
      next_st = '0;
      if (req.valid) begin
         if (in_vendor && !req.from_vendor) begin
            next_st.deny = 1'b1; // R19
         end else begin
            next_st.grant = 1'b1;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         st <= '0;
      end else begin
         st <= next_st;
      end
   end

   assign grant = st.grant;
   assign deny  = st.deny;
endmodule
`default_nettype wire

// >>> verilog/fpec_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// Notes on behaviour
// R01 - Unlock needs 73H then 8CH writes
// R02 - Bad value or order relocks controller
// R03 - 95H as third command erases page
// R04 - 63H third command mass erases, debugger only
// R05 - 5EH while locked redirects next select write
// R06 - Command writes and state reads share FF8H
// R07 - State codes for lock, unlock, protect select
// R08 - Busy codes 001, 010, 100 in upper bits
// R09 - State read free of side effects, top zero
// R10 - FF9H writes page select unless redirected
// R11 - Page field gives address bits 15..9
// R12 - Info bit maps area at FE00H-FFFFH
// R13 - Page erase targets the active page
// R14 - Protect bits reset clear, user cannot clear
// R15 - Eight protect bits, one per sector
// R16 - Two bytes form kHz timing value
// R17 - Host keeps clock 10 kHz to 20 MHz
// R18 - Lower 8 KB user, upper 4 K vendor
// R19 - User code blocked from vendor region
// R20 - Page rewrite must match, else relock
// R21 - Page erase completion relocks controller
module fpec_ctrl
   import fpec_pkg::*;
#(
   parameter int PAGE_W = 7
)
(
   input  wire logic          clk,
   input  wire logic          reset,
   input  wire fpec_reg_req_t reg_req,
   input  wire fpec_mem_req_t mem_req,
   input  wire logic          prog_start,
   output logic [7:0]         rdata,
   output logic               rvalid,
   output logic [PAGE_W-1:0]  active_page,
   output logic               info_area_select,
   output logic [7:0]         sector_lock_bits,
   output logic               erase_page,
   output logic               erase_mass,
   output logic               program_busy,
   output logic               cpu_stall,
   output logic               mem_grant,
   output logic               mem_deny
);
   typedef enum {
      S_LOCKED,
      S_FIRST,
      S_SECOND,
      S_UNLOCKED,
      S_PROT_SEL,
      S_PROGRAM,
      S_PAGE_ERASE,
      S_MASS_ERASE
   } fpec_state_t;

   typedef struct packed {
      fpec_state_t  fsm;
      logic [7:0]   page_and_info_select;
      logic [7:0]   sector_lock_mask;
      logic [7:0]   clock_khz_high_byte;
      logic [7:0]   clock_khz_low_byte;
      logic         page_armed;
      logic         page_active;
      logic [7:0]   rdata;
      logic         rvalid;
      logic [31:0]  busy_us;
      logic         erase_page;
      logic         erase_mass;
      logic         prog_busy;
      logic         stall;
   } fpec_ctrl_state_t;

   fpec_ctrl_state_t st;
   fpec_ctrl_state_t next_st;
   logic [15:0]      clock_khz_value;
   logic             tick_us;
   logic             busy;
   logic [5:0]       controller_state_field;
   logic [2:0]       page_sector;
   logic             page_protected;

   // Concatenated kHz value times all flash operations
   assign clock_khz_value = {st.clock_khz_high_byte, st.clock_khz_low_byte}; // R16
   assign busy = (st.fsm == S_PROGRAM) || (st.fsm == S_PAGE_ERASE) ||
                 (st.fsm == S_MASS_ERASE);

   fpec_tick u_tick (
      .clk     (clk),
      .reset   (reset),
      .run     (busy),
      .khz     (clock_khz_value),
      .tick_us (tick_us)
   );

   fpec_guard u_guard (
      .clk   (clk),
      .reset (reset),
      .req   (mem_req),
      .grant (mem_grant),
      .deny  (mem_deny)
   );

   // Eight sectors of 512 bytes; upper page bits are ignored, so pages wrap onto sectors 0..7
   assign page_sector    = st.page_and_info_select[2:0]; // R15
   assign page_protected = st.sector_lock_mask[page_sector];

   // State readback encoding
   always_comb begin
      case (st.fsm)
         S_LOCKED:     controller_state_field = ST_LOCKED; // R07
         S_FIRST:      controller_state_field = ST_FIRST;
         S_SECOND:     controller_state_field = ST_SECOND;
         S_UNLOCKED:   controller_state_field = ST_UNLOCKED;
         S_PROT_SEL:   controller_state_field = ST_PROT_SEL;
         S_PROGRAM:    controller_state_field = ST_PROGRAM; // R08
         S_PAGE_ERASE: controller_state_field = ST_PAGE_ER;
         S_MASS_ERASE: controller_state_field = ST_MASS_ER;
         default:      controller_state_field = ST_LOCKED;
      endcase
   end

   // Register writes, sequencer and erase timing
   always_comb begin
      next_st = st;
      next_st.rvalid     = 1'b0;
      next_st.erase_page = 1'b0;
      next_st.erase_mass = 1'b0;

      // Reads have no side effect; state reads have upper two bits zero
      if (reg_req.rd) begin
         next_st.rvalid = 1'b1;
         if (reg_req.addr == ADDR_COMMAND) begin
            next_st.rdata = {2'b00, controller_state_field}; // R06 R09
         end else if (reg_req.addr == ADDR_PAGE_SEL) begin
            next_st.rdata = st.page_and_info_select;
         end else if (reg_req.addr == ADDR_KHZ_HIGH) begin
            next_st.rdata = st.clock_khz_high_byte;
         end else if (reg_req.addr == ADDR_KHZ_LOW) begin
            next_st.rdata = st.clock_khz_low_byte;
         end else begin
            next_st.rdata = 8'h00;
         end
      end

      // Running operations count down microseconds; erases then relock, program returns to unlocked
      if (busy) begin
         if (tick_us) begin
            if (st.busy_us <= 32'h1) begin
               next_st.fsm         = S_LOCKED; // R21
               next_st.page_active = 1'b0;
               next_st.page_armed  = 1'b0;
            end else begin
               next_st.busy_us = st.busy_us - 32'h1;
            end
         end
      end else if (reg_req.wr && reg_req.addr == ADDR_COMMAND) begin
         // Commands; any unexpected value or order relocks
         next_st.fsm         = S_LOCKED; // R02
         next_st.page_active = 1'b0;
         next_st.page_armed  = 1'b0;
         case (st.fsm)
            S_LOCKED, S_PROT_SEL: begin
               if (reg_req.wdata == CMD_UNLOCK_1) begin
                  next_st.fsm = S_FIRST; // R01
               end else if (reg_req.wdata == CMD_PROT_ACCESS && st.fsm == S_LOCKED) begin
                  next_st.fsm = S_PROT_SEL; // R05
               end
            end
            S_FIRST: begin
               if (reg_req.wdata == CMD_UNLOCK_2) begin
                  next_st.fsm        = S_SECOND; // R01
                  next_st.page_armed = 1'b1;
               end
            end
            S_SECOND, S_UNLOCKED: begin
               // Debugger needs no page rewrite before erase
               if (st.page_active || reg_req.debug) begin
                  if (reg_req.wdata == CMD_PAGE_ERASE &&
                      (!page_protected || reg_req.debug)) begin
                     next_st.fsm        = S_PAGE_ERASE; // R03 R13
                     next_st.busy_us    = 32'(PAGE_ERASE_US);
                     next_st.erase_page = 1'b1;
                  end else if (reg_req.wdata == CMD_MASS_ERASE && reg_req.debug) begin
                     next_st.fsm        = S_MASS_ERASE; // R04
                     next_st.busy_us    = 32'(MASS_ERASE_US);
                     next_st.erase_mass = 1'b1;
                  end
               end
            end
            default: begin
               next_st.fsm = S_LOCKED;
            end
         endcase
      end else if (reg_req.wr && reg_req.addr == ADDR_PAGE_SEL) begin
         if (st.fsm == S_PROT_SEL) begin
            // Redirected write: user may only set bits, debugger may clear
            if (reg_req.debug) begin
               next_st.sector_lock_mask = reg_req.wdata;
            end else begin
               next_st.sector_lock_mask = st.sector_lock_mask | reg_req.wdata; // R14
            end
            next_st.fsm = S_LOCKED;
         end else if (st.fsm == S_SECOND && st.page_armed) begin
            // Rewrite must repeat the stored page to make it active
            next_st.page_armed = 1'b0;
            if (reg_req.wdata == st.page_and_info_select) begin
               next_st.page_active = 1'b1; // R20
               next_st.fsm         = S_UNLOCKED;
            end else begin
               next_st.page_and_info_select = reg_req.wdata;
               next_st.fsm                  = S_LOCKED;
            end
         end else if (st.fsm == S_LOCKED || reg_req.debug) begin
            next_st.page_and_info_select = reg_req.wdata; // R10
            if (reg_req.debug && st.fsm == S_SECOND) begin
               next_st.page_active = 1'b1;
               next_st.fsm         = S_UNLOCKED;
            end
         end else begin
            // Changing page while open would widen access, so it relocks
            next_st.page_and_info_select = reg_req.wdata;
            next_st.fsm                  = S_LOCKED;
            next_st.page_active          = 1'b0;
         end
      end else if (reg_req.wr && reg_req.addr == ADDR_KHZ_HIGH) begin
         next_st.clock_khz_high_byte = reg_req.wdata;
      end else if (reg_req.wr && reg_req.addr == ADDR_KHZ_LOW) begin
         next_st.clock_khz_low_byte = reg_req.wdata;
      end else if (prog_start && st.fsm == S_UNLOCKED) begin
         // Byte program keeps the page open afterwards
         next_st.fsm     = S_PROGRAM;
         next_st.busy_us = 32'(PROGRAM_US);
      end

      // Byte program returns to unlocked rather than locked
      if (st.fsm == S_PROGRAM && tick_us && st.busy_us <= 32'h1) begin
         next_st.fsm         = S_UNLOCKED;
         next_st.page_active = 1'b1;
      end

      // Busy flags kept in flops so the pins carry no decode glitches
      next_st.prog_busy = (next_st.fsm == S_PROGRAM); // R08
      next_st.stall     = (next_st.fsm == S_PROGRAM) || (next_st.fsm == S_PAGE_ERASE) ||
                          (next_st.fsm == S_MASS_ERASE);
   end

   // All registers clear on reset
   always_ff @(posedge clk) begin
      if (reset) begin
         st     <= '0;
         st.fsm <= S_LOCKED;
      end else begin
         st <= next_st;
      end
   end

   // Page field drives address bits 15..9; info bit maps FE00H upward
   assign active_page      = st.page_and_info_select[PAGE_W-1:0]; // R11
   assign info_area_select = st.page_and_info_select[INFO_BIT]; // R12
   assign sector_lock_bits = st.sector_lock_mask;
   assign erase_page       = st.erase_page;
   assign erase_mass       = st.erase_mass;
   assign program_busy     = st.prog_busy;
   assign cpu_stall        = st.stall;
   assign rdata            = st.rdata;
   assign rvalid           = st.rvalid;
endmodule
`default_nettype wire

// >>> tb/fpec_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module fpec_ctrl_chk
   import fpec_pkg::*;
#(
   parameter int PAGE_W = 7
)
(
   input wire logic          clk,
   input wire logic          reset,
   input wire fpec_reg_req_t reg_req,
   input wire fpec_mem_req_t mem_req,
   input wire logic          prog_start,
   input wire logic [7:0]    rdata,
   input wire logic          rvalid,
   input wire logic [PAGE_W-1:0] active_page,
   input wire logic          info_area_select,
   input wire logic [7:0]    sector_lock_bits,
   input wire logic          erase_page,
   input wire logic          erase_mass,
   input wire logic          program_busy,
   input wire logic          cpu_stall,
   input wire logic          mem_grant,
   input wire logic          mem_deny
);
   // Causes seen on the register and memory request inputs
   wire logic cmd_wr = reg_req.wr && reg_req.addr == ADDR_COMMAND;
   wire logic sel_wr = reg_req.wr && reg_req.addr == ADDR_PAGE_SEL;
   wire logic pe_cmd = cmd_wr && reg_req.wdata == CMD_PAGE_ERASE;
   wire logic me_cmd = cmd_wr && reg_req.wdata == CMD_MASS_ERASE && reg_req.debug;
   wire logic user_vendor = mem_req.valid && !mem_req.from_vendor
                            && mem_req.addr >= USER_LIMIT && mem_req.addr < VENDOR_LIMIT;

   default clocking @(posedge clk); endclocking
   default disable iff (reset);

   // An erase start and the stall it must hold for a while
   sequence s_erase_start;
      erase_page || erase_mass;
   endsequence
   sequence s_stall_run;
      cpu_stall [*3];
   endsequence

   a_read_answer: assert property (reg_req.rd |=> rvalid)
      else $error("read strobe got no answer");
   a_state_top_zero: assert property (rvalid && $past(reg_req.addr) == ADDR_COMMAND
      |-> rdata[7:6] == 2'b00) else $error("state read top bits not zero");
   a_pe_cause: assert property (erase_page |-> $past(pe_cmd) || $past(pe_cmd, 2))
      else $error("page erase without its command");
   a_pe_one_pulse: assert property (erase_page |=> !erase_page)
      else $error("page erase pulse too long");
   a_me_debug_only: assert property (erase_mass |-> $past(me_cmd) || $past(me_cmd, 2))
      else $error("mass erase without debugger command");
   a_erase_stalls: assert property (s_erase_start |-> ##1 s_stall_run)
      else $error("erase did not stall the cpu");
   a_prog_stalls: assert property (program_busy |-> cpu_stall)
      else $error("program busy without stall");
   a_lock_sticky: assert property (($past(sector_lock_bits) & ~sector_lock_bits) != 8'h00
      |-> $past(reg_req.debug) || $past(reg_req.debug, 2)) else $error("protect bit cleared");
   a_info_needs_write: assert property ($changed(info_area_select)
      |-> $past(sel_wr) || $past(sel_wr, 2)) else $error("info select moved unasked");
   a_mem_one_answer: assert property (mem_req.valid |=> mem_grant != mem_deny)
      else $error("memory request answer malformed");
   a_vendor_denied: assert property (user_vendor |=> mem_deny)
      else $error("user reached vendor region");
endmodule

bind fpec_ctrl fpec_ctrl_chk #(.PAGE_W(PAGE_W)) u_chk (.clk(clk), .reset(reset),
   .reg_req(reg_req), .mem_req(mem_req), .prog_start(prog_start), .rdata(rdata),
   .rvalid(rvalid), .active_page(active_page), .info_area_select(info_area_select),
   .sector_lock_bits(sector_lock_bits), .erase_page(erase_page), .erase_mass(erase_mass),
   .program_busy(program_busy), .cpu_stall(cpu_stall), .mem_grant(mem_grant),
   .mem_deny(mem_deny));
`default_nettype wire

// >>> tb/fpec_host_model.sv
`timescale 1ns/100ps
`default_nettype none
// CPU or debugger side: one register access at a time, strobes one cycle wide
module fpec_host_model
   import fpec_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rvalid,
   input  wire logic [7:0] rdata,
   output fpec_reg_req_t   req
);
   initial req = '0;

   // Released bus shows inverted leftovers so a stale value never looks live
   task automatic idle_bus(input logic [11:0] a, input logic [7:0] d);
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d, debug: 1'b0};
   endtask

   task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic dbg);
      @(posedge clk);
      req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d, debug: dbg};
      idle_bus(a, d);
      // Return once the written state has settled, so callers never see the old value
      @(negedge clk);
   endtask

   // Answer is awaited for a few cycles only; none leaves unknown data
   task automatic rd(input logic [11:0] a, output logic [7:0] d);
      d = 8'bx;
      @(posedge clk);
      req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00, debug: 1'b0};
      idle_bus(a, 8'h00);
      for (int i = 0; i < 4; i++) begin
         @(negedge clk);
         if (rvalid === 1'b1) begin
            d = rdata;
            break;
         end
      end
   endtask
endmodule
`default_nettype wire

// >>> tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import fpec_pkg::*;
   logic          clk, reset, prog_start, rvalid, info_sel, erase_page, erase_mass;
   logic          program_busy, cpu_stall, mem_grant, mem_deny;
   fpec_reg_req_t reg_req;
   fpec_mem_req_t mem_req;
   logic [7:0]    rdata, lock_bits, d;
   logic [6:0]    page, act_page;
   logic [15:0]   ma;
   logic          fv;
   int            num_errors = 0, n_compared = 0, cycles = 0, n_pe = 0, n_me = 0;
   int            seed = 32'heb4f;

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   fpec_ctrl #(.PAGE_W(7)) u_dut (.clk(clk), .reset(reset), .reg_req(reg_req),
      .mem_req(mem_req), .prog_start(prog_start), .rdata(rdata), .rvalid(rvalid),
      .active_page(act_page), .info_area_select(info_sel), .sector_lock_bits(lock_bits),
      .erase_page(erase_page), .erase_mass(erase_mass), .program_busy(program_busy),
      .cpu_stall(cpu_stall), .mem_grant(mem_grant), .mem_deny(mem_deny));
   fpec_host_model u_host (.clk(clk), .rvalid(rvalid), .rdata(rdata), .req(reg_req));

   // Pulse tally and hang guard; the ceiling leaves room for one page erase
   always @(posedge clk) begin
      cycles++;
      n_pe += erase_page;
      n_me += erase_mass;
      if (cycles == 60000) begin
         num_errors++;
         stop_test();
      end
   end

   task automatic stop_test();
      $display("checks %0d mismatches %0d", n_compared, num_errors);
      if (num_errors == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic st(input logic [5:0] code);
      u_host.rd(ADDR_COMMAND, d);
      chk("state", d, {2'b00, code});
   endtask

   // Host keeps the documented order: page p, two keys, then page q, which opens only if it equals p
   task automatic unlock(input logic [6:0] p, input logic [6:0] q);
      u_host.wr(ADDR_PAGE_SEL, {1'b0, p}, 1'b0);
      u_host.wr(ADDR_COMMAND, CMD_UNLOCK_1, 1'b0);
      u_host.wr(ADDR_COMMAND, CMD_UNLOCK_2, 1'b0);
      u_host.wr(ADDR_PAGE_SEL, {1'b0, q}, 1'b0);
   endtask

   // Expected grant and deny pair for one memory access
   function automatic logic [7:0] gd_exp(input logic [15:0] a, input logic v);
      logic ok;
      ok = v || a < USER_LIMIT || a >= VENDOR_LIMIT;
      return {6'h0, ok, !ok};
   endfunction

   task automatic mem(input logic [15:0] a, input logic v);
      @(posedge clk);
      mem_req <= '{valid: 1'b1, write: a[0], addr: a, from_vendor: v};
      @(posedge clk);
      mem_req <= '{valid: 1'b0, write: 1'b0, addr: ~a, from_vendor: 1'b0};
      @(negedge clk);
      chk("grant deny", {6'h0, mem_grant, mem_deny}, gd_exp(a, v));
   endtask

   initial begin
      reset = 1'b1;
      prog_start = 1'b0;
      mem_req = '0;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      for (int a = 8; a < 12; a++) begin
         u_host.rd(12'hff0 + 12'(a), d);
         chk("reset value", d, REG_RESET);
      end
      page = 7'($random(seed));
      u_host.wr(ADDR_PAGE_SEL, {1'b0, page}, 1'b0);
      u_host.wr(ADDR_COMMAND, CMD_UNLOCK_1, 1'b0);
      st(ST_FIRST);
      u_host.wr(ADDR_COMMAND, CMD_UNLOCK_2, 1'b0);
      st(ST_SECOND);
      u_host.wr(ADDR_PAGE_SEL, {1'b0, page}, 1'b0);
      st(ST_UNLOCKED);
      chk("page", {1'b0, act_page}, {1'b0, page});
      u_host.wr(ADDR_COMMAND, 8'h42, 1'b0);
      st(ST_LOCKED);
      u_host.wr(ADDR_COMMAND, CMD_UNLOCK_1, 1'b0);
      u_host.wr(ADDR_COMMAND, CMD_UNLOCK_1, 1'b0);
      st(ST_LOCKED);
      unlock(page, page ^ 7'h01);
      st(ST_LOCKED);
      // 1000 kHz claims a 1 MHz clock, inside the supported range
      u_host.wr(ADDR_KHZ_HIGH, 8'h03, 1'b0);
      u_host.wr(ADDR_KHZ_LOW, 8'he8, 1'b0);
      u_host.rd(ADDR_KHZ_HIGH, d);
      chk("khz high", d, 8'h03);
      u_host.rd(ADDR_KHZ_LOW, d);
      chk("khz low", d, 8'he8);
      unlock(page, page);
      u_host.wr(ADDR_COMMAND, CMD_PAGE_ERASE, 1'b0);
      st(ST_PAGE_ER);
      chk("stall", {7'h0, cpu_stall}, 8'h01);
      chk("erase pulses", 8'(n_pe), 8'h01);
      chk("erased page", {1'b0, act_page}, {1'b0, page});
      for (int i = 0; i < 30000 && cpu_stall !== 1'b0; i++) @(posedge clk);
      st(ST_LOCKED);
      chk("stall", {7'h0, cpu_stall}, 8'h00);
      unlock(page, page);
      @(posedge clk);
      prog_start <= 1'b1;
      @(posedge clk);
      prog_start <= 1'b0;
      st(ST_PROGRAM);
      chk("program busy", {7'h0, program_busy}, 8'h01);
      for (int i = 0; i < 3000 && program_busy !== 1'b0; i++) @(posedge clk);
      u_host.wr(ADDR_COMMAND, 8'h42, 1'b0);
      mem(16'h1fff, 1'b0);
      mem(16'h2000, 1'b0);
      mem(16'h2fff, 1'b1);
      for (int i = 0; i < 8; i++) begin
         ma = 16'($unsigned($random(seed)) % 12288);
         fv = 1'($random(seed));
         mem(ma, fv);
      end
      unlock(page, page);
      u_host.wr(ADDR_COMMAND, CMD_MASS_ERASE, 1'b0);
      st(ST_LOCKED);
      u_host.wr(ADDR_COMMAND, CMD_UNLOCK_1, 1'b1);
      u_host.wr(ADDR_COMMAND, CMD_UNLOCK_2, 1'b1);
      u_host.wr(ADDR_COMMAND, CMD_MASS_ERASE, 1'b1);
      st(ST_MASS_ER);
      chk("mass pulses", 8'(n_me), 8'h01);
      // Mass erase is too long to sit out, so a reset ends it
      @(posedge clk);
      reset <= 1'b1;
      repeat (5) @(posedge clk);
      reset <= 1'b0;
      u_host.wr(ADDR_COMMAND, CMD_PROT_ACCESS, 1'b0);
      st(ST_PROT_SEL);
      u_host.wr(ADDR_PAGE_SEL, 8'ha5, 1'b0);
      chk("protect", lock_bits, 8'ha5);
      chk("info", {7'h0, info_sel}, 8'h00);
      u_host.wr(ADDR_COMMAND, CMD_PROT_ACCESS, 1'b0);
      u_host.wr(ADDR_PAGE_SEL, 8'h00, 1'b0);
      chk("protect", lock_bits, 8'ha5);
      u_host.wr(ADDR_COMMAND, CMD_PROT_ACCESS, 1'b0);
      u_host.wr(ADDR_PAGE_SEL, 8'h5a, 1'b0);
      chk("protect", lock_bits, 8'hff);
      u_host.wr(ADDR_PAGE_SEL, {1'b1, page}, 1'b0);
      chk("info", {7'h0, info_sel}, 8'h01);
      chk("protect", lock_bits, 8'hff);
      stop_test();
   end
endmodule
`default_nettype wire
